/* spp_port.sv */
// Pipelined burst static memory: synchronous port with its storage array
`timescale 1ns/1ps
`default_nettype none

module spp_port
#(
  parameter int ADDR_W = spp_pkg::SPP_ADDR_W,
  parameter bit HAS_DEPTH_LOW_SEL = 1'b1
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire spp_pkg::spp_ctrl_t i_ctrl,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order,
  input wire spp_pkg::spp_word_t i_data,
  output var spp_pkg::spp_word_t o_data,
  output logic o_data_oe
);
  import spp_pkg::*;

  localparam int DEPTH = 2 ** ADDR_W;
  localparam int BASE_W = ADDR_W - SPP_BEAT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and asynchronous pin synchronisers

  logic [1:0] rst_n_ff;
  logic rst_n;
  logic [1:0] oe_n_sync_ff;
  logic [1:0] sleep_sync_ff;
  logic [1:0] order_sync_ff;
  logic oe_n_s;
  logic sleep_s;
  logic interleave_s;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_n_ff <= 2'h0;
    end
    else
    begin
      rst_n_ff <= {rst_n_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_n_ff[1];

  // Output enable and sleep are asynchronous pins; the strap is static but
  // still crosses in, so nothing downstream sees a metastable level
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_n_sync_ff <= {2{SPP_OE_N_RST}};
      sleep_sync_ff <= {2{SPP_SLEEP_RST}};
      order_sync_ff <= {2{SPP_ORDER_RST}};
    end
    else
    begin
      oe_n_sync_ff <= {oe_n_sync_ff[0], i_output_enable_n};
      sleep_sync_ff <= {sleep_sync_ff[0], i_sleep_request};
      order_sync_ff <= {order_sync_ff[0], i_burst_order};
    end
  end

  assign oe_n_s = oe_n_sync_ff[1];
  assign sleep_s = sleep_sync_ff[1];
  assign interleave_s = order_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Burst offset

  function automatic logic [SPP_BEAT_W-1:0] burst_off(
    input logic [SPP_BEAT_W-1:0] start,
    input logic [SPP_BEAT_W-1:0] beat,
    input logic interleave
  );
    logic [SPP_BEAT_W-1:0] sum;
    sum = start + beat;
    burst_off = interleave ? (start ^ beat) : sum;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access control

  spp_state_t state_ff, nxt_state;
  logic [BASE_W-1:0] base_ff, nxt_base;
  logic [SPP_BEAT_W-1:0] start_ff, nxt_start;
  logic [SPP_BEAT_W-1:0] beat_ff, nxt_beat;
  spp_word_t data_ff, nxt_data;
  logic data_oe_ff, nxt_data_oe;
  logic [ADDR_W-1:0] eff_addr;
  logic [SPP_LANES-1:0] wr_lanes;
  logic [SPP_LANES-1:0] req_lanes;
  logic selected;
  logic cpu_go;
  logic ctrl_go;
  logic reading;
  spp_word_t rd_word;

  always_comb
  begin
    selected = !i_ctrl.select_primary_n && i_ctrl.select_depth_high
      && (!i_ctrl.select_depth_low_n || !HAS_DEPTH_LOW_SEL);
    cpu_go = !i_ctrl.cpu_addr_strobe_n && !i_ctrl.select_primary_n;
    ctrl_go = !i_ctrl.ctrl_addr_strobe_n && !cpu_go;
    if (!i_ctrl.all_bytes_write_n)
    begin
      req_lanes = SPP_LANES_ALL;
    end
    else if (!i_ctrl.lane_write_qualifier_n)
    begin
      req_lanes = ~i_ctrl.byte_lane_write_n;
    end
    else
    begin
      req_lanes = SPP_LANES_NONE;
    end
    nxt_state = state_ff;
    nxt_base = base_ff;
    nxt_start = start_ff;
    nxt_beat = beat_ff;
    eff_addr = {base_ff, burst_off(start_ff, beat_ff, interleave_s)};
    wr_lanes = SPP_LANES_NONE;
    reading = 1'b0;
    case (state_ff)
      SPP_DESEL, SPP_FIRST, SPP_BURST, SPP_SLEEP:
      begin
        if (sleep_s)
        begin
          nxt_state = SPP_SLEEP;
        end
        else if (cpu_go || ctrl_go)
        begin
          if (selected)
          begin
            // A start from idle masks the pins for one cycle
            nxt_state = (state_ff == SPP_BURST || state_ff == SPP_FIRST)
              ? SPP_BURST : SPP_FIRST;
            nxt_base = i_addr[ADDR_W-1:SPP_BEAT_W];
            nxt_start = i_addr[SPP_BEAT_W-1:0];
            nxt_beat = SPP_BEAT_RST;
            eff_addr = i_addr;
            wr_lanes = cpu_go ? SPP_LANES_NONE : req_lanes;
            reading = (wr_lanes == SPP_LANES_NONE);
          end
          else
          begin
            nxt_state = SPP_DESEL;
          end
        end
        else if (state_ff == SPP_FIRST || state_ff == SPP_BURST)
        begin
          nxt_state = SPP_BURST;
          if (!i_ctrl.burst_step_n)
          begin
            nxt_beat = beat_ff + SPP_BEAT_ONE;
          end
          eff_addr = {base_ff, burst_off(start_ff, nxt_beat, interleave_s)};
          wr_lanes = req_lanes;
          reading = (wr_lanes == SPP_LANES_NONE);
        end
        else
        begin
          nxt_state = SPP_DESEL;
        end
      end
      default:
      begin
        nxt_state = SPP_DESEL;
      end
    endcase
    nxt_data = reading ? rd_word : data_ff;
    nxt_data_oe = !oe_n_s && reading && (nxt_state == SPP_BURST);
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= SPP_DESEL;
      base_ff <= '0;
      start_ff <= SPP_BEAT_RST;
      beat_ff <= SPP_BEAT_RST;
      data_ff <= '0;
      data_oe_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      base_ff <= nxt_base;
      start_ff <= nxt_start;
      beat_ff <= nxt_beat;
      data_ff <= nxt_data;
      data_oe_ff <= nxt_data_oe;
    end
  end

  assign o_data = data_ff;
  assign o_data_oe = data_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Storage: one array per lane, so each lane has a single writer

  for (genvar g = 0; g < SPP_LANES; g++)
  begin : g_lane
    logic [SPP_LANE_W-1:0] lane_mem [DEPTH];

    // Storage has no reset: contents survive reset and sleep alike
    always_ff @(posedge i_clk)
    begin
      if (wr_lanes[g])
      begin
        lane_mem[eff_addr] <= {i_data.parity_lines[g],
          i_data.dq[g*SPP_BYTE_W +: SPP_BYTE_W]};
      end
    end

    assign rd_word.parity_lines[g] = lane_mem[eff_addr][SPP_BYTE_W];
    assign rd_word.dq[g*SPP_BYTE_W +: SPP_BYTE_W] =
      lane_mem[eff_addr][SPP_BYTE_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [SPP_LANES-1:0] wr_seen_ff;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_seen_ff <= SPP_LANES_NONE;
    end
    else
    begin
      wr_seen_ff <= wr_lanes;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_awake_start;
    !sleep_s && selected && (cpu_go || ctrl_go);
  endsequence

  sequence s_step;
    (state_ff == SPP_BURST) && !sleep_s && !cpu_go && ctrl_go == 1'b0
      && !i_ctrl.burst_step_n;
  endsequence

  sel_decode_a: assert property (
    (!sleep_s && !i_ctrl.ctrl_addr_strobe_n && !selected)
      |=> state_ff == SPP_DESEL)
    else $error("Strobe without full select did not deselect");

  cpu_ignore_a: assert property (
    (!sleep_s && i_ctrl.select_primary_n && i_ctrl.ctrl_addr_strobe_n)
      |=> $stable(base_ff) && $stable(start_ff))
    else $error("Processor strobe acted with primary select high");

  addr_capture_a: assert property (
    s_awake_start
      |=> base_ff == $past(i_addr[ADDR_W-1:SPP_BEAT_W])
        && start_ff == $past(i_addr[SPP_BEAT_W-1:0])
        && beat_ff == SPP_BEAT_RST)
    else $error("Start did not capture the address");

  cpu_first_a: assert property (
    (s_awake_start and !i_ctrl.cpu_addr_strobe_n)
      |=> wr_seen_ff == SPP_LANES_NONE)
    else $error("Write controls honoured on processor start cycle");

  global_write_a: assert property (
    (state_ff == SPP_BURST && !sleep_s && !cpu_go && !ctrl_go
      && !i_ctrl.all_bytes_write_n) |=> wr_seen_ff == SPP_LANES_ALL)
    else $error("Global write did not write every lane");

  lane_write_a: assert property (
    (state_ff == SPP_BURST && !sleep_s && !cpu_go && !ctrl_go
      && i_ctrl.all_bytes_write_n)
      |=> wr_seen_ff == ($past(i_ctrl.lane_write_qualifier_n)
        ? SPP_LANES_NONE : ~$past(i_ctrl.byte_lane_write_n)))
    else $error("Lane writes do not match lane selects");

  burst_step_a: assert property (
    s_step |=> beat_ff == $past(beat_ff) + SPP_BEAT_ONE)
    else $error("Burst counter did not step");

  burst_order_a: assert property (
    (state_ff == SPP_BURST && !cpu_go && !ctrl_go && !sleep_s)
      |-> eff_addr[SPP_BEAT_W-1:0] == (interleave_s
        ? (start_ff ^ (beat_ff + {1'b0, !i_ctrl.burst_step_n}))
        : (start_ff + (beat_ff + {1'b0, !i_ctrl.burst_step_n}))))
    else $error("Burst offset out of order");

  first_mask_a: assert property (
    ((state_ff == SPP_DESEL) and s_awake_start) |=> !o_data_oe)
    else $error("Pins driven on first cycle after deselect");

  read_pipe_a: assert property (
    (state_ff == SPP_BURST && !sleep_s && !cpu_go && !ctrl_go
      && req_lanes == SPP_LANES_NONE)
      |=> o_data == $past(rd_word))
    else $error("Read data not from the previous edge's address");

  sleep_quiet_a: assert property (
    sleep_s [*2] |-> (state_ff == SPP_SLEEP) && !o_data_oe
      && wr_seen_ff == SPP_LANES_NONE)
    else $error("Activity while asleep");

  oe_off_a: assert property (
    oe_n_s |=> !o_data_oe)
    else $error("Pins driven with output enable high");

endmodule // spp_port

`default_nettype wire

/* spp_pkg.sv */
// Shared constants and types for the pipelined burst static memory port
`default_nettype none

package spp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths

  localparam int SPP_ADDR_W = 19;
  localparam int SPP_LANES = 4;
  localparam int SPP_BYTE_W = 8;
  localparam int SPP_LANE_W = SPP_BYTE_W + 1;
  localparam int SPP_BEAT_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and fixed beat and lane constants

  localparam logic [SPP_BEAT_W-1:0] SPP_BEAT_RST = 2'h0;
  localparam logic [SPP_BEAT_W-1:0] SPP_BEAT_ONE = 2'h1;
  localparam logic SPP_OE_N_RST = 1'h1;
  localparam logic SPP_SLEEP_RST = 1'h0;
  localparam logic SPP_ORDER_RST = 1'h1;
  localparam logic [SPP_LANES-1:0] SPP_LANES_NONE = 4'h0;
  localparam logic [SPP_LANES-1:0] SPP_LANES_ALL = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // Types

  typedef enum logic [1:0] {
    SPP_DESEL = 2'b00,
    SPP_FIRST = 2'b01,
    SPP_BURST = 2'b10,
    SPP_SLEEP = 2'b11
  } spp_state_t;

  // One data word as it sits on the pins: parity above the bytes
  typedef struct packed {
    logic [SPP_LANES-1:0] parity_lines;
    logic [SPP_LANES*SPP_BYTE_W-1:0] dq;
  } spp_word_t;

  // Synchronous control pins; bit 0 of the lane vector is lane a
  typedef struct packed {
    logic select_primary_n;
    logic select_depth_high;
    logic select_depth_low_n;
    logic cpu_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic all_bytes_write_n;
    logic lane_write_qualifier_n;
    logic [SPP_LANES-1:0] byte_lane_write_n;
  } spp_ctrl_t;

endpackage

`default_nettype wire

/* spp_ctrl_model.sv */
// Controller model driving the memory port's synchronous pins
`timescale 1ns/1ps
`default_nettype none
module spp_ctrl_model
(
  input wire logic i_clk,
  output var logic [5:0] o_addr,
  output var spp_pkg::spp_ctrl_t o_ctrl,
  output var spp_pkg::spp_word_t o_data
);
  import spp_pkg::*;
  // Released data lines show the inverse of the last value, so a design
  // that samples them outside a write cannot see stable data by chance
  task automatic drive(input logic [5:0] a, input spp_ctrl_t c,
    input spp_word_t d, input logic we);
    @(posedge i_clk);
    o_addr <= a;
    o_ctrl <= c;
    o_data <= we ? d : ~o_data;
  endtask
  initial
  begin
    o_addr = 6'h00;
    o_ctrl = 12'h5FF;
    o_data = 36'h0;
  end
endmodule // spp_ctrl_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spp_pkg::*;
  typedef struct {logic oe; logic chk; spp_word_t d;} spp_note_t;
  localparam spp_ctrl_t IDLE = 12'h5FF;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic oe_n = 1'b0;
  logic sleep = 1'b0;
  logic order = 1'b1;
  logic [5:0] addr;
  spp_ctrl_t ctrl;
  spp_word_t wdata;
  spp_word_t rdata;
  logic rd_oe;
  logic [35:0] mem [64];
  spp_note_t q[$];
  int pend = 0;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0775E2FC;
  logic active = 1'b0;
  logic [3:0] base;
  logic [1:0] st;
  logic [1:0] beat;

  always #5 i_clk = ~i_clk;

  spp_port #(.ADDR_W(6)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(addr), .i_ctrl(ctrl), .i_output_enable_n(oe_n),
    .i_sleep_request(sleep), .i_burst_order(order), .i_data(wdata),
    .o_data(rdata), .o_data_oe(rd_oe));
  spp_ctrl_model model (.i_clk(i_clk), .o_addr(addr), .o_ctrl(ctrl),
    .o_data(wdata));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [5:0] loc();
    return {base, order ? st ^ beat : st + beat};
  endfunction
  task automatic check_oe(input logic exp);
    samples_checked++;
    if (rd_oe !== exp)
    begin
      errors++;
      $display("FAIL o_data_oe expected %b seen %b", exp, rd_oe);
    end
  endtask
  task automatic check_word(input spp_word_t exp);
    samples_checked++;
    if (rdata !== exp)
    begin
      errors++;
      $display("FAIL o_data expected %h seen %h", exp, rdata);
    end
  endtask
  // Notes pushed after one edge are due after the next edge
  always @(negedge i_clk)
  begin
    repeat (pend)
    begin
      check_oe(q[0].oe);
      if (q[0].chk)
        check_word(q[0].d);
      void'(q.pop_front());
    end
    pend = q.size();
  end
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input logic [5:0] a, input spp_ctrl_t c,
    input logic [35:0] d, input logic we, input logic oe, input logic chk);
    spp_note_t n;
    model.drive(a, c, d, we);
    n.oe = oe;
    n.chk = chk;
    n.d = mem[loc()];
    q.push_back(n);
  endtask
  // Only used while deselected or asleep, where idle cycles start nothing
  task automatic idle(input int n);
    repeat (n) cyc(6'h00, IDLE, 36'h0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic desel(input int k);
    spp_ctrl_t c;
    c = IDLE;
    c[7] = 1'b0;
    c[11:9] = (k == 0) ? 3'b110 : (k == 1) ? 3'b000 : 3'b011;
    cyc(6'(rnd()), c, 36'h0, 1'b0, 1'b0, 1'b0);
    active = 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic g_n, input logic q_n,
    input logic [3:0] ln);
    spp_ctrl_t c;
    logic [31:0] r;
    logic [35:0] d;
    logic w;
    r = rnd();
    d = {r[3:0], rnd()};
    c = IDLE;
    c[7] = 1'b0;
    c[5:0] = {g_n, q_n, ln};
    // No lane enabled turns the strobe cycle into a read of the same word
    w = !g_n || (!q_n && ln != 4'hF);
    base = a[5:2];
    st = a[1:0];
    beat = 2'h0;
    for (int i = 0; i < 4; i++)
      if (!sleep && (!g_n || (!q_n && !ln[i])))
      begin
        mem[a][32+i] = d[32+i];
        mem[a][8*i +: 8] = d[8*i +: 8];
      end
    cyc(a, c, d, 1'b1, !w && active && !oe_n && !sleep,
      !w && !sleep);
    active = !sleep;
  endtask
  // Continuation write at the current burst word, advance held high
  task automatic cwr(input logic g_n, input logic [3:0] ln);
    spp_ctrl_t c;
    logic [31:0] r;
    logic [35:0] d;
    logic w;
    r = rnd();
    d = {r[3:0], rnd()};
    c = IDLE;
    c[5:0] = {g_n, 1'b0, ln};
    w = !g_n || ln != 4'hF;
    for (int i = 0; i < 4; i++)
      if (!g_n || !ln[i])
      begin
        mem[loc()][32+i] = d[32+i];
        mem[loc()][8*i +: 8] = d[8*i +: 8];
      end
    cyc(6'(rnd()), c, d, 1'b1, !w && !oe_n, !w);
  endtask
  task automatic rd(input logic [5:0] a, input logic cpu, input int beats);
    spp_ctrl_t c;
    c = IDLE;
    // Processor start also drops the other strobe, write and advance
    c[8:5] = cpu ? 4'b0000 : 4'b1011;
    base = a[5:2];
    st = a[1:0];
    beat = 2'h0;
    cyc(a, c, 36'h0, 1'b0, active & !oe_n, 1'b1);
    active = 1'b1;
    for (int b = 0; b < beats; b++)
    begin
      c = IDLE;
      c[6] = 1'b0;
      beat = beat + 2'h1;
      cyc(6'(rnd()), c, 36'h0, 1'b0, !oe_n, 1'b1);
    end
    c = IDLE;
    c[11] = 1'b1;
    c[8] = 1'b0;
    cyc(6'(rnd()), c, 36'h0, 1'b0, !oe_n, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    for (int i = 0; i < 64; i++)
      wr(6'(i), 1'b0, 1'b1, 4'hF);
    for (int k = 0; k < 3; k++)
    begin
      desel(k);
      rd(6'(rnd()), k == 1, 5);
    end
    rd(6'(rnd()), 1'b1, 0);
    rd(6'(rnd()), 1'b0, 1);
    for (int i = 0; i < 12; i++)
    begin
      logic [31:0] r;
      r = rnd();
      wr(r[5:0], 1'b1, r[9] & r[10], r[8:5]);
      rd(r[5:0], r[11], 0);
      cwr(r[12], r[16:13]);
      rd(loc(), 1'b0, 0);
    end
    desel(1);
    order <= 1'b0;
    idle(4);
    rd(6'(rnd()), 1'b0, 5);
    desel(2);
    order <= 1'b1;
    oe_n <= 1'b1;
    idle(4);
    rd(6'(rnd()), 1'b1, 3);
    desel(0);
    oe_n <= 1'b0;
    sleep <= 1'b1;
    idle(4);
    wr(6'h2A, 1'b0, 1'b1, 4'hF);
    sleep <= 1'b0;
    idle(4);
    rd(6'h2A, 1'b1, 1);
    desel(2);
    idle(2);
    repeat (2) @(posedge i_clk);
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    errors++;
    $display("FAIL watchdog expected end seen hang");
    close_out();
  end
endmodule // testbench
`default_nettype wire
